/* logic/aost_pkg.sv */
package aost_pkg;
    typedef logic [31:0] aost_word_t;
    typedef logic [15:0] aost_half_t;
    typedef enum logic [2:0] {
        AOST_PWR_ACTIVE,
        AOST_PWR_IDLE,
        AOST_PWR_SAVE,
        AOST_PWR_SLEEP,
        AOST_PWR_RESTORE
    } aost_pwr_e;
    typedef enum logic [1:0] {
        AOST_CMD_NONE,
        AOST_CMD_IDLE,
        AOST_CMD_DEEP
    } aost_cmd_e;
endpackage : aost_pkg

/* logic/aost_power_ctrl.sv */
// Register access over Avalon-MM and the address map were chosen for this implementation.
`timescale 1ns/100ps
`include "aost_regs.svh"
module aost_power_ctrl #(
    parameter int unsigned WDT_TIMEOUT_TICKS = `AOST_WDT_TIMEOUT_TICKS,
    parameter int unsigned WDT_LOWMARK_TICKS = `AOST_WDT_LOWMARK_TICKS
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire aost_pkg::aost_word_t avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output aost_pkg::aost_word_t avs_readdata,
    output logic avs_waitrequest,
    input wire logic rc_clk_in,
    input wire logic xtal32_clk_in,
    input wire logic any_irq_in,
    input wire logic ext_irq_in,
    input wire logic dbg_wake_in,
    input wire logic serial_activity_in,
    input wire aost_pkg::aost_half_t gpio_in,
    input wire aost_pkg::aost_half_t gpio_core_out,
    input wire logic ctx_save_done,
    input wire logic ctx_restore_done,
    output aost_pkg::aost_half_t gpio_out,
    output logic cpu_halt,
    output logic ctx_save_req,
    output logic ctx_restore_req,
    output logic core_regulator_output,
    output logic lv_domain_on,
    output logic gpio_freeze,
    output logic serial_rx_en,
    output logic chip_reset_req,
    output logic sleep_wake,
    output logic st_cmp_a_irq,
    output logic st_cmp_b_irq,
    output logic wdt_low_irq
);
    import aost_pkg::*;

    logic ack_q;
    aost_word_t rdata_q;
    logic [`AOST_CTRL_W-1:0] ctrl_q;
    aost_half_t cal_div_q;
    aost_half_t cal_cnt_q;
    logic cal_tick_q;
    aost_half_t cmp_a_q;
    aost_half_t cmp_b_q;
    logic [`AOST_FLG_W-1:0] flags_q;
    logic [`AOST_WK_W-1:0] wake_cause_q;
    aost_half_t gpio_wake_q;
    aost_half_t gpio_snap_q;
    aost_half_t gpio_out_q;
    aost_half_t wdt_cnt_q;
    logic wdt_rst_q;
    logic rc_q;
    logic xt_q;
    aost_pwr_e state_q;
    aost_pwr_e state_d;
    logic halt_q;
    logic save_q;
    logic restore_q;
    logic reg_on_q;
    logic freeze_q;
    logic rx_en_q;
    aost_half_t st_count;
    logic [1:0] st_match;

    // Bus slave: one wait state, so every access completes at its second edge.
    wire bus_req = avs_read | avs_write;
    wire bus_take = bus_req & ~ack_q;
    wire bus_fire = bus_req & ack_q;
    wire wr_fire = avs_write & ack_q;
    assign avs_waitrequest = bus_req & ~ack_q;
    assign avs_readdata = rdata_q;

    wire [31:0] be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                           {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wire [31:0] wd_m = avs_writedata & be_mask;

    wire sel_ctrl = avs_address == `AOST_OFF_CTRL;
    wire sel_cal = avs_address == `AOST_OFF_CAL_DIV;
    wire sel_wdt = avs_address == `AOST_OFF_WDT_RESTART;
    wire sel_cmpa = avs_address == `AOST_OFF_CMP_A;
    wire sel_cmpb = avs_address == `AOST_OFF_CMP_B;
    wire sel_cnt = avs_address == `AOST_OFF_COUNT;
    wire sel_flags = avs_address == `AOST_OFF_FLAGS;
    wire sel_pwr = avs_address == `AOST_OFF_PWR;
    wire sel_wake = avs_address == `AOST_OFF_WAKE_CAUSE;
    wire sel_gpw = avs_address == `AOST_OFF_GPIO_WAKE;

    wire [31:0] ctrl_new = ({23'h000000, ctrl_q} & ~be_mask) | wd_m;
    wire [31:0] cal_new = ({16'h0000, cal_div_q} & ~be_mask) | wd_m;
    wire [31:0] cmpa_new = ({16'h0000, cmp_a_q} & ~be_mask) | wd_m;
    wire [31:0] cmpb_new = ({16'h0000, cmp_b_q} & ~be_mask) | wd_m;
    wire [31:0] gpw_new = ({16'h0000, gpio_wake_q} & ~be_mask) | wd_m;

    wire wdt_restart = wr_fire & sel_wdt;
    wire cmd_idle = wr_fire & sel_pwr & (wd_m[1:0] == AOST_CMD_IDLE);
    wire cmd_deep = wr_fire & sel_pwr & (wd_m[1:0] == AOST_CMD_DEEP);
    wire [`AOST_FLG_W-1:0] flags_clr = (wr_fire & sel_flags) ? wd_m[`AOST_FLG_W-1:0] : '0;
    wire [`AOST_WK_W-1:0] wake_clr = (wr_fire & sel_wake) ? wd_m[`AOST_WK_W-1:0] : '0;

    wire [31:0] rd_mux =
        sel_ctrl ? {23'h000000, ctrl_q} :
        sel_cal ? {16'h0000, cal_div_q} :
        sel_wdt ? {16'h0000, wdt_cnt_q} :
        sel_cmpa ? {16'h0000, cmp_a_q} :
        sel_cmpb ? {16'h0000, cmp_b_q} :
        sel_cnt ? {16'h0000, st_count} :
        sel_flags ? {29'h00000000, flags_q} :
        sel_pwr ? {29'h00000000, state_q} :
        sel_wake ? {27'h0000000, wake_cause_q} :
        sel_gpw ? {16'h0000, gpio_wake_q} : 32'h00000000;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h00000000;
        end else begin
            ack_q <= bus_take;
            if (bus_take & avs_read) begin
                rdata_q <= rd_mux;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_q <= `AOST_CTRL_RST;
            cal_div_q <= 16'(`AOST_CAL_DIV_RST);
            cmp_a_q <= `AOST_CMP_RST;
            cmp_b_q <= `AOST_CMP_RST;
            gpio_wake_q <= `AOST_GPIO_WAKE_RST;
        end else if (wr_fire) begin
            if (sel_ctrl) ctrl_q <= ctrl_new[`AOST_CTRL_W-1:0];
            if (sel_cal) cal_div_q <= cal_new[15:0];
            if (sel_cmpa) cmp_a_q <= cmpa_new[15:0];
            if (sel_cmpb) cmp_b_q <= cmpb_new[15:0];
            if (sel_gpw) gpio_wake_q <= gpw_new[15:0];
        end
    end

    wire wdt_en = ctrl_q[`AOST_CTRL_WDT_EN];
    wire ser_wake_en = ctrl_q[`AOST_CTRL_SER_WAKE];

    // Both slow clocks arrive synchronous; a rising edge becomes a one-cycle tick.
    wire rc_tick = rc_clk_in & ~rc_q;
    wire xt_tick = xtal32_clk_in & ~xt_q;
    // A divide ratio of zero behaves as one rather than stalling the timer.
    wire cal_hit = rc_tick & (({1'b0, cal_cnt_q} + 17'h00001) >= {1'b0, cal_div_q});

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rc_q <= 1'b0;
            xt_q <= 1'b0;
            cal_cnt_q <= 16'h0000;
            cal_tick_q <= 1'b0;
        end else begin
            rc_q <= rc_clk_in;
            xt_q <= xtal32_clk_in;
            cal_tick_q <= cal_hit;
            if (cal_hit) begin
                cal_cnt_q <= 16'h0000;
            end else if (rc_tick) begin
                cal_cnt_q <= 16'(cal_cnt_q + 16'h0001);
            end
        end
    end

    // Watchdog counts RC ticks only, so its period follows the raw RC trim.
    wire wdt_to_hit = wdt_en & rc_tick & (wdt_cnt_q == 16'(WDT_TIMEOUT_TICKS - 1));
    wire wdt_low_hit = wdt_en & rc_tick & (wdt_cnt_q == 16'(WDT_LOWMARK_TICKS - 1));

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            wdt_cnt_q <= 16'h0000;
            wdt_rst_q <= 1'b0;
        end else begin
            wdt_rst_q <= wdt_to_hit;
            if (!wdt_en || wdt_restart || wdt_to_hit) begin
                wdt_cnt_q <= 16'h0000;
            end else if (rc_tick) begin
                wdt_cnt_q <= 16'(wdt_cnt_q + 16'h0001);
            end
        end
    end

    aost_sleep_timer u_sleep_timer (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .tick_cal(cal_tick_q),
        .tick_32k(xt_tick),
        .clk_sel(ctrl_q[`AOST_CTRL_CLK_SEL]),
        .div(ctrl_q[`AOST_CTRL_DIV_MSB:`AOST_CTRL_DIV_LSB]),
        .cmp_a(cmp_a_q),
        .cmp_b(cmp_b_q),
        .count_q(st_count),
        .match_q(st_match)
    );

    // A new event beats a clear that lands in the same cycle.
    wire [`AOST_FLG_W-1:0] flags_set = {wdt_low_hit, st_match[1], st_match[0]};
    wire in_wake_window = (state_q == AOST_PWR_SLEEP) | (state_q == AOST_PWR_RESTORE);
    wire gpio_chg = |((gpio_in ^ gpio_snap_q) & gpio_wake_q);
    wire [`AOST_WK_W-1:0] wake_vec = {gpio_chg, serial_activity_in & ser_wake_en,
                                      dbg_wake_in, ext_irq_in, st_match[0]};
    wire wake_any = |wake_vec;
    wire [`AOST_WK_W-1:0] wake_set = in_wake_window ? wake_vec : '0;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            flags_q <= '0;
            wake_cause_q <= '0;
        end else begin
            flags_q <= (flags_q & ~flags_clr) | flags_set;
            wake_cause_q <= (wake_cause_q & ~wake_clr) | wake_set;
        end
    end

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            AOST_PWR_ACTIVE: begin
                if (cmd_idle) state_d = AOST_PWR_IDLE;
                else if (cmd_deep) state_d = AOST_PWR_SAVE;
            end
            AOST_PWR_IDLE: begin
                if (any_irq_in | dbg_wake_in) state_d = AOST_PWR_ACTIVE;
            end
            AOST_PWR_SAVE: begin
                if (ctx_save_done) state_d = AOST_PWR_SLEEP;
            end
            AOST_PWR_SLEEP: begin
                if (wake_any) state_d = AOST_PWR_RESTORE;
            end
            AOST_PWR_RESTORE: begin
                if (ctx_restore_done) state_d = AOST_PWR_ACTIVE;
            end
            default: state_d = AOST_PWR_ACTIVE;
        endcase
    end

    wire next_sleep = state_d == AOST_PWR_SLEEP;
    wire next_frozen = next_sleep | (state_d == AOST_PWR_RESTORE);
    wire next_rx = (state_d == AOST_PWR_ACTIVE) | (state_d == AOST_PWR_IDLE);

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= AOST_PWR_ACTIVE;
            halt_q <= 1'b0;
            save_q <= 1'b0;
            restore_q <= 1'b0;
            reg_on_q <= 1'b1;
            freeze_q <= 1'b0;
            rx_en_q <= 1'b1;
        end else begin
            state_q <= state_d;
            halt_q <= state_d != AOST_PWR_ACTIVE;
            save_q <= state_d == AOST_PWR_SAVE;
            restore_q <= state_d == AOST_PWR_RESTORE;
            reg_on_q <= ~next_sleep;
            freeze_q <= next_frozen;
            rx_en_q <= next_rx;
        end
    end

    // Pins keep their entry level until the restored core drives them again.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            gpio_out_q <= 16'h0000;
            gpio_snap_q <= 16'h0000;
        end else begin
            if (!next_frozen) gpio_out_q <= gpio_core_out;
            if (state_q == AOST_PWR_SAVE) gpio_snap_q <= gpio_in;
        end
    end

    assign gpio_out = gpio_out_q;
    assign cpu_halt = halt_q;
    assign ctx_save_req = save_q;
    assign ctx_restore_req = restore_q;
    assign core_regulator_output = reg_on_q;
    assign lv_domain_on = reg_on_q;
    assign gpio_freeze = freeze_q;
    assign serial_rx_en = rx_en_q;
    assign chip_reset_req = wdt_rst_q;
    assign sleep_wake = flags_q[`AOST_FLG_CMP_A];
    assign st_cmp_a_irq = flags_q[`AOST_FLG_CMP_A];
    assign st_cmp_b_irq = flags_q[`AOST_FLG_CMP_B];
    assign wdt_low_irq = flags_q[`AOST_FLG_WDT_LOW];

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    a_cal_tick_rc: assert property (cal_tick_q |-> $past(rc_tick) && cal_cnt_q == 16'h0000)
        else $error("calibrated tick not aligned to RC divide");
    a_wdt_off_quiet: assert property (!$past(wdt_en) |-> !chip_reset_req)
        else $error("disabled watchdog reset the chip");
    a_wdt_timeout: assert property (wdt_to_hit |=> chip_reset_req ##1 !chip_reset_req)
        else $error("watchdog timeout did not pulse chip reset");
    a_wdt_low_mark: assert property (wdt_low_hit |=> flags_q[`AOST_FLG_WDT_LOW])
        else $error("low watermark flag missing");
    a_wdt_restart_zero: assert property (wdt_restart |=> wdt_cnt_q == 16'h0000)
        else $error("watchdog restart did not zero the count");
    a_cmp_b_no_wake: assert property ($rose(sleep_wake) |-> $past(st_match[0]))
        else $error("wake raised without compare A");
    a_idle_release: assert property (state_q == AOST_PWR_IDLE && any_irq_in |=> !cpu_halt)
        else $error("idle core not released by interrupt");
    a_deep_power: assert property (state_q == AOST_PWR_SLEEP |-> !core_regulator_output
        && gpio_freeze && !lv_domain_on)
        else $error("regulator or freeze wrong in deep sleep");
    a_gpio_hold: assert property (gpio_freeze && $past(gpio_freeze) |-> $stable(gpio_out))
        else $error("frozen pin output changed");
    a_serial_block: assert property (!(state_q inside {AOST_PWR_ACTIVE, AOST_PWR_IDLE})
        |-> !serial_rx_en)
        else $error("serial reception enabled during wake sequence");
    a_wake_record: assert property (state_q == AOST_PWR_SLEEP && wake_any
        |=> state_q == AOST_PWR_RESTORE && wake_cause_q != '0)
        else $error("wake event not recorded");
    a_save_handshake: assert property (state_q == AOST_PWR_SAVE && ctx_save_done
        |=> !ctx_save_req && !core_regulator_output)
        else $error("save handshake did not reach deep sleep");

    c_deep_cycle: cover property (state_q == AOST_PWR_SLEEP ##[1:1000] state_q == AOST_PWR_ACTIVE);
    c_wdt_reset: cover property (chip_reset_req);
    c_idle_wake: cover property (state_q == AOST_PWR_IDLE ##1 state_q == AOST_PWR_ACTIVE);
    c_gpio_wake: cover property (state_q == AOST_PWR_SLEEP && gpio_chg);
endmodule : aost_power_ctrl

/* logic/aost_regs.svh */
`ifndef AOST_REGS_SVH
`define AOST_REGS_SVH

// Register byte offsets on the bus.
`define AOST_OFF_CTRL 6'h00
`define AOST_OFF_CAL_DIV 6'h04
`define AOST_OFF_WDT_RESTART 6'h08
`define AOST_OFF_CMP_A 6'h0C
`define AOST_OFF_CMP_B 6'h10
`define AOST_OFF_COUNT 6'h14
`define AOST_OFF_FLAGS 6'h18
`define AOST_OFF_PWR 6'h1C
`define AOST_OFF_WAKE_CAUSE 6'h20
`define AOST_OFF_GPIO_WAKE 6'h24

// Control register fields.
`define AOST_CTRL_WDT_EN 0
`define AOST_CTRL_CLK_SEL 1
`define AOST_CTRL_DIV_LSB 4
`define AOST_CTRL_DIV_MSB 7
`define AOST_CTRL_SER_WAKE 8
`define AOST_CTRL_W 9

// Flag register fields.
`define AOST_FLG_CMP_A 0
`define AOST_FLG_CMP_B 1
`define AOST_FLG_WDT_LOW 2
`define AOST_FLG_W 3

// Wake cause fields.
`define AOST_WK_TIMER 0
`define AOST_WK_EXT_IRQ 1
`define AOST_WK_DEBUG 2
`define AOST_WK_SERIAL 3
`define AOST_WK_GPIO 4
`define AOST_WK_W 5

// Reset values.
`define AOST_CTRL_RST 9'h000
`define AOST_CMP_RST 16'hFFFF
`define AOST_GPIO_WAKE_RST 16'h0000

// Timing.
`define AOST_RC_HZ 10000
`define AOST_CAL_HZ 1000
`define AOST_MS_PER_S 1000
`define AOST_CAL_DIV_RST (`AOST_RC_HZ / `AOST_CAL_HZ)
`define AOST_WDT_TIMEOUT_MS 2000
`define AOST_WDT_LOWMARK_MS 1750
`define AOST_WDT_TIMEOUT_TICKS ((`AOST_WDT_TIMEOUT_MS * `AOST_RC_HZ) / `AOST_MS_PER_S)
`define AOST_WDT_LOWMARK_TICKS ((`AOST_WDT_LOWMARK_MS * `AOST_RC_HZ) / `AOST_MS_PER_S)
`define AOST_ST_DIV_MAX 4'hA

`endif

/* logic/aost_sleep_timer.sv */
`timescale 1ns/100ps
`include "aost_regs.svh"
module aost_sleep_timer (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic tick_cal,
    input wire logic tick_32k,
    input wire logic clk_sel,
    input wire logic [3:0] div,
    input wire aost_pkg::aost_half_t cmp_a,
    input wire aost_pkg::aost_half_t cmp_b,
    output aost_pkg::aost_half_t count_q,
    output logic [1:0] match_q
);
    import aost_pkg::*;

    logic [9:0] pre_q;
    wire src_tick = clk_sel ? tick_32k : tick_cal;
    wire [3:0] pre_n = (div > `AOST_ST_DIV_MAX) ? `AOST_ST_DIV_MAX : div;
    wire [9:0] pre_mask = 10'((11'h001 << pre_n) - 11'h001);
    wire tmr_tick = src_tick & ((pre_q & pre_mask) == pre_mask);
    wire [1:0][15:0] cmp = {cmp_b, cmp_a};

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pre_q <= 10'h000;
            count_q <= 16'h0000;
        end else begin
            if (src_tick) begin
                pre_q <= 10'(pre_q + 10'h001);
            end
            if (tmr_tick) begin
                count_q <= 16'(count_q + 16'h0001);
            end
        end
    end

    // Each channel compares on the timer tick, so a match fires once per wrap.
    for (genvar ch = 0; ch < 2; ch++) begin : g_cmp
        always_ff @(posedge sys_clk or negedge resetn) begin
            if (!resetn) begin
                match_q[ch] <= 1'b0;
            end else begin
                match_q[ch] <= tmr_tick & (count_q == cmp[ch]);
            end
        end
    end

    a_count_step: assert property (@(posedge sys_clk) disable iff (!resetn)
        tmr_tick |=> count_q == 16'($past(count_q) + 16'h0001))
        else $error("sleep timer did not advance on its tick");
    a_match_time: assert property (@(posedge sys_clk) disable iff (!resetn)
        match_q[0] |-> $past(tmr_tick) && $past(count_q) == $past(cmp_a))
        else $error("compare A match without equal count");
    a_div_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
        src_tick && div == 4'h0 |-> tmr_tick)
        else $error("divide by one skipped a source tick");
endmodule : aost_sleep_timer

/* testbench/aost_core_model.sv */
`timescale 1ns/100ps
module aost_core_model (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic ctx_save_req,
    input wire logic ctx_restore_req,
    output logic ctx_save_done,
    output logic ctx_restore_done
);
    // The engine answers late on purpose, so SAVE and RESTORE last several cycles.
    logic [2:0] sv_q;
    logic [2:0] rs_q;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sv_q <= 3'h0;
            rs_q <= 3'h0;
        end else begin
            sv_q <= !ctx_save_req ? 3'h0 : (sv_q == 3'h3 ? sv_q : sv_q + 3'h1);
            rs_q <= !ctx_restore_req ? 3'h0 : (rs_q == 3'h3 ? rs_q : rs_q + 3'h1);
        end
    end
    assign ctx_save_done = ctx_save_req && (sv_q == 3'h3);
    assign ctx_restore_done = ctx_restore_req && (rs_q == 3'h3);
endmodule : aost_core_model

/* testbench/tb_top.sv */
`timescale 1ns/100ps
`include "aost_regs.svh"
module tb_top;
    import aost_pkg::*;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic [5:0] avs_address = 6'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    aost_word_t avs_writedata = 32'h0;
    aost_word_t avs_readdata;
    logic avs_waitrequest, rc_clk_in = 1'b0, xtal32_clk_in = 1'b0;
    logic any_irq_in = 1'b0, ext_irq_in = 1'b0, dbg_wake_in = 1'b0;
    logic serial_activity_in = 1'b0;
    aost_half_t gpio_in = 16'h0000;
    aost_half_t gpio_core_out = 16'hA5A5;
    aost_half_t gpio_out;
    logic ctx_save_done, ctx_restore_done, cpu_halt, ctx_save_req, ctx_restore_req;
    logic core_regulator_output, lv_domain_on, gpio_freeze, serial_rx_en, chip_reset_req;
    logic sleep_wake, st_cmp_a_irq, st_cmp_b_irq, wdt_low_irq;
    int error_cnt = 0;
    int num_checks = 0;
    int rst_cnt = 0;
    aost_power_ctrl #(.WDT_TIMEOUT_TICKS(8), .WDT_LOWMARK_TICKS(6)) u_aost_power_ctrl (
        .sys_clk(sys_clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .rc_clk_in(rc_clk_in), .xtal32_clk_in(xtal32_clk_in), .any_irq_in(any_irq_in),
        .ext_irq_in(ext_irq_in), .dbg_wake_in(dbg_wake_in),
        .serial_activity_in(serial_activity_in),
        .gpio_in(gpio_in), .gpio_core_out(gpio_core_out), .ctx_save_done(ctx_save_done),
        .ctx_restore_done(ctx_restore_done), .gpio_out(gpio_out), .cpu_halt(cpu_halt),
        .ctx_save_req(ctx_save_req), .ctx_restore_req(ctx_restore_req),
        .core_regulator_output(core_regulator_output), .lv_domain_on(lv_domain_on),
        .gpio_freeze(gpio_freeze), .serial_rx_en(serial_rx_en),
        .chip_reset_req(chip_reset_req), .sleep_wake(sleep_wake),
        .st_cmp_a_irq(st_cmp_a_irq), .st_cmp_b_irq(st_cmp_b_irq), .wdt_low_irq(wdt_low_irq));
    aost_core_model u_aost_core_model (
        .sys_clk(sys_clk), .resetn(resetn), .ctx_save_req(ctx_save_req),
        .ctx_restore_req(ctx_restore_req), .ctx_save_done(ctx_save_done),
        .ctx_restore_done(ctx_restore_done));
    initial forever #4 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        if (chip_reset_req === 1'b1) rst_cnt <= rst_cnt + 1;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    // Holds the request until waitrequest is sampled low; the bench timeout ends a hang.
    task automatic bus(input logic wr, input logic [5:0] a, input aost_word_t d,
                       output aost_word_t q);
        @(posedge sys_clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        #1;
    endtask : bus
    task automatic wr(input logic [5:0] a, input aost_word_t d);
        aost_word_t q;
        bus(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [5:0] a, output aost_word_t q);
        bus(1'b0, a, 32'h0, q);
    endtask : rd
    task automatic tick(input bit xt, input int n);
        repeat (n) begin
            @(posedge sys_clk);
            if (xt) xtal32_clk_in <= 1'b1;
            else rc_clk_in <= 1'b1;
            @(posedge sys_clk);
            xtal32_clk_in <= 1'b0;
            rc_clk_in <= 1'b0;
            @(posedge sys_clk);
        end
        repeat (3) @(posedge sys_clk);
        #1;
    endtask : tick
    task automatic t_reset;
        aost_word_t q;
        rd(`AOST_OFF_CTRL, q);
        chk(q, 32'h0, "ctrl");
        rd(`AOST_OFF_CAL_DIV, q);
        chk(q, 32'hA, "cal div");
        rd(`AOST_OFF_CMP_A, q);
        chk(q, 32'hFFFF, "cmp a");
        rd(6'h3C, q);
        chk(q, 32'h0, "unmapped");
        rd(`AOST_OFF_PWR, q);
        chk(q, 32'h0, "mode");
        chk({cpu_halt, core_regulator_output}, 32'h1, "halt reg");
        $display("test reset done");
    endtask : t_reset
    task automatic t_timer;
        aost_word_t c, q;
        wr(`AOST_OFF_CAL_DIV, 32'h1);
        wr(`AOST_OFF_CTRL, 32'h0);
        rd(`AOST_OFF_COUNT, c);
        // A channel matches on the tick that finds the count at its compare value.
        wr(`AOST_OFF_CMP_A, {16'h0, c[15:0] + 16'h1});
        wr(`AOST_OFF_CMP_B, c);
        tick(1'b0, 1);
        chk({st_cmp_b_irq, st_cmp_a_irq, sleep_wake}, 32'h4, "b only");
        rd(`AOST_OFF_COUNT, q);
        chk(q, {16'h0, c[15:0] + 16'h1}, "count");
        tick(1'b0, 1);
        chk({st_cmp_b_irq, st_cmp_a_irq, sleep_wake}, 32'h7, "a wake");
        wr(`AOST_OFF_FLAGS, 32'h3);
        chk({st_cmp_b_irq, st_cmp_a_irq, sleep_wake}, 32'h0, "clear");
        $display("test timer done");
    endtask : t_timer
    task automatic t_prescale;
        aost_word_t c, q;
        int code[2] = '{11, 1};
        int n[2] = '{2048, 4};
        for (int i = 0; i < 2; i++) begin
            wr(`AOST_OFF_CTRL, 32'(code[i] << 4) | 32'h2);
            rd(`AOST_OFF_COUNT, c);
            tick(1'b1, n[i]);
            rd(`AOST_OFF_COUNT, q);
            chk({16'h0, q[15:0] - c[15:0]}, 32'h2, "prescale");
        end
        $display("test prescale done");
    endtask : t_prescale
    task automatic t_wdog;
        aost_word_t q;
        wr(`AOST_OFF_CTRL, 32'h0);
        tick(1'b0, 10);
        rd(`AOST_OFF_WDT_RESTART, q);
        chk(q + 32'(rst_cnt), 32'h0, "wdt off");
        wr(`AOST_OFF_CTRL, 32'h1);
        wr(`AOST_OFF_WDT_RESTART, 32'h0);
        tick(1'b0, 5);
        wr(`AOST_OFF_WDT_RESTART, 32'h0);
        tick(1'b0, 5);
        chk(wdt_low_irq, 1'b0, "low early");
        rd(`AOST_OFF_WDT_RESTART, q);
        chk(q, 32'h5, "wdt count");
        tick(1'b0, 1);
        chk(wdt_low_irq, 1'b1, "low mark");
        tick(1'b0, 1);
        chk(rst_cnt, 0, "early reset");
        tick(1'b0, 1);
        chk(rst_cnt, 1, "timeout");
        wr(`AOST_OFF_CTRL, 32'h0);
        wr(`AOST_OFF_FLAGS, 32'h7);
        $display("test watchdog done");
    endtask : t_wdog
    task automatic t_idle;
        aost_word_t q;
        wr(`AOST_OFF_PWR, 32'h1);
        chk({cpu_halt, serial_rx_en}, 32'h3, "idle");
        rd(`AOST_OFF_PWR, q);
        chk(q, 32'h1, "idle mode");
        @(posedge sys_clk);
        any_irq_in <= 1'b1;
        repeat (3) @(posedge sys_clk);
        any_irq_in <= 1'b0;
        #1;
        chk(cpu_halt, 1'b0, "idle exit");
        $display("test idle done");
    endtask : t_idle
    task automatic t_deep;
        aost_word_t q;
        wr(`AOST_OFF_PWR, 32'h2);
        for (int i = 0; i < 50 && core_regulator_output !== 1'b0; i++) @(posedge sys_clk);
        chk({core_regulator_output, lv_domain_on}, 32'h0, "reg off");
        chk({gpio_freeze, serial_rx_en, ctx_save_req}, 32'h4, "sleep");
        gpio_core_out <= 16'h5A5A;
        repeat (4) @(posedge sys_clk);
        chk(gpio_out, 32'hA5A5, "frozen");
        ext_irq_in <= 1'b1;
        for (int i = 0; i < 50 && ctx_restore_req !== 1'b1; i++) @(posedge sys_clk);
        ext_irq_in <= 1'b0;
        dbg_wake_in <= 1'b1;
        chk({core_regulator_output, serial_rx_en}, 32'h2, "restore");
        @(posedge sys_clk);
        dbg_wake_in <= 1'b0;
        for (int i = 0; i < 50 && cpu_halt !== 1'b0; i++) @(posedge sys_clk);
        repeat (2) @(posedge sys_clk);
        #1;
        chk({serial_rx_en, gpio_out}, 32'h15A5A, "awake");
        rd(`AOST_OFF_WAKE_CAUSE, q);
        chk(q, 32'h6, "cause");
        wr(`AOST_OFF_WAKE_CAUSE, 32'h1F);
        rd(`AOST_OFF_WAKE_CAUSE, q);
        chk(q, 32'h0, "cause clr");
        $display("test deep done");
    endtask : t_deep
    task automatic t_wake;
        aost_word_t c, q;
        rd(`AOST_OFF_COUNT, c);
        wr(`AOST_OFF_CMP_B, c);
        wr(`AOST_OFF_GPIO_WAKE, 32'h1);
        wr(`AOST_OFF_CTRL, 32'h100);
        wr(`AOST_OFF_PWR, 32'h2);
        for (int i = 0; i < 50 && core_regulator_output !== 1'b0; i++) @(posedge sys_clk);
        tick(1'b0, 1);
        chk({st_cmp_b_irq, core_regulator_output}, 32'h2, "b no wake");
        @(posedge sys_clk);
        gpio_in <= 16'h0001;
        serial_activity_in <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk(serial_rx_en, 1'b0, "rx held");
        serial_activity_in <= 1'b0;
        for (int i = 0; i < 50 && cpu_halt !== 1'b0; i++) @(posedge sys_clk);
        rd(`AOST_OFF_WAKE_CAUSE, q);
        chk(q, 32'h18, "cause gpio serial");
        $display("test wake done");
    endtask : t_wake
    task automatic wrap_up;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : wrap_up
    initial begin
        #200000;
        error_cnt++;
        $display("BAD %0t timeout", $time);
        wrap_up();
    end
    initial begin
        repeat (6) @(posedge sys_clk);
        resetn <= 1'b1;
        t_reset();
        t_timer();
        t_prescale();
        t_wdog();
        t_idle();
        t_deep();
        t_wake();
        wrap_up();
    end
endmodule : tb_top
